// ---- hw/dmars_seq.sv ----
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dmars_defines.svh"
//////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////
module dmars_seq
   import dmars_pkg::*;
(
   input  wire logic        i_clk,            // Processor clock.
   input  wire logic        i_rst,            // Sync reset, active high.
   input  wire logic [1:0]  i_drq,            // Request pins, async.
   input  wire logic        i_hold_req,       // External bus hold.
   input  wire logic        i_refresh_req,    // Refresh wants the bus.
   input  wire logic        i_cpu_bus_req,    // CPU wants a bus cycle.
   input  wire logic        i_bus_ready,      // Low adds a wait state.
   input  wire logic        i_timer_max,      // Timer hit max count.
   input  wire logic        i_nmi,            // Non-maskable interrupt.
   input  wire logic        i_intr_return,    // Interrupt return done.
   input  wire logic [7:0]  i_addr,           // Register byte address.
   input  wire logic [15:0] i_wdata,          // Register write data.
   input  wire logic        i_wr,             // Write strobe.
   input  wire logic        i_rd,             // Read strobe.
   output logic      [15:0] o_rdata,          // Read data, next cycle.
   output logic             o_dma_cycle_status, // High in DMA cycles.
   output logic             o_first_bus_state,  // First bus state.
   output logic             o_second_bus_state, // Second bus state.
   output logic             o_fetch_cycle,    // DMA fetch in progress.
   output logic             o_deposit_cycle,  // DMA deposit running.
   output logic             o_dma_channel,    // Channel of DMA cycle.
   output logic             o_cpu_cycle,      // CPU cycle running.
   output logic             o_refresh_cycle,  // Refresh cycle running.
   output logic             o_hold_ack        // Bus held externally.
);

   //////////////////////////////////////////////////////////////////////
   // Storage and state.
   logic [5:0]   ctrl [2];        // Channel control registers.
   logic [15:0]  cnt [2];         // Transfer counts.
   logic         halt_flag;       // DMA halt flag.
   logic         slave_mode;      // Interrupt controller in slave mode.
   logic         timer_req;       // Shared latched timer request.
   logic         last_ch;         // Channel that ran last.
   logic         chan;            // Channel of current DMA cycle.
   logic [1:0]   gap_cnt;         // Destination mode bus release.
   dmars_state_t state;           // Bus sequencer state.
   dmars_owner_t owner;           // Owner of current cycle.
   dmars_state_t next_state;      // Next sequencer state.
   dmars_owner_t next_owner;      // Next owner.
   dmars_req_if  rq ();           // Request carrier.

   // Channel request from its mode, the pin and the timer latch.
   function automatic logic chan_req(input logic [5:0] c,
                                     input logic dma_request_input, input logic treq);
      logic [1:0] syn;
      syn = c[`DMARS_CTRL_SYN_HI:`DMARS_CTRL_SYN_LO];
      if (!c[`DMARS_CTRL_START])
         chan_req = 1'b0;
      else if (c[`DMARS_CTRL_TSEL])
         chan_req = treq;
      else if (syn == SYN_NONE)
         chan_req = 1'b1;
      else if (syn == SYN_OFF)
         chan_req = 1'b0;
      else
         chan_req = dma_request_input;
   endfunction

   dmars_req_sync #(.LAT(`DMARS_REQ_LAT_CLK)) u_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .rq    (rq.sync_side)
   );
   assign rq.drq_pin = i_drq;

   //////////////////////////////////////////////////////////////////////
   // Decode and arbitration.
   wire halt_eff = halt_flag && !slave_mode;
   wire dst_end  = (state == ST_T4) && (owner == OWN_DEPOSIT)
                   && (ctrl[chan][2:1] == SYN_DST);
   wire gap_ok   = !dst_end && (gap_cnt < 2'(`DMARS_DST_GAP_CLK));
   wire [1:0] req;
   assign req[0] = chan_req(ctrl[0], rq.drq_seen[0], timer_req)
                   && !halt_eff && gap_ok;
   assign req[1] = chan_req(ctrl[1], rq.drq_seen[1], timer_req)
                   && !halt_eff && gap_ok;
   wire pri0 = ctrl[0][`DMARS_CTRL_PRI];
   wire pri1 = ctrl[1][`DMARS_CTRL_PRI];
   wire pick = (req == 2'h3) ? ((pri0 != pri1) ? pri1 : !last_ch)
                             : req[1];
   wire in_t4_fetch = (state == ST_T4) && (owner == OWN_FETCH);
   wire opp = (state == ST_IDLE) || ((state == ST_T4) && !in_t4_fetch);
   wire win_hold = opp && i_hold_req;
   wire win_ref  = opp && !i_hold_req && i_refresh_req;
   wire win_dma  = opp && !i_hold_req && !i_refresh_req
                   && (req != 2'h0);
   wire win_cpu  = opp && !i_hold_req && !i_refresh_req
                   && (req == 2'h0) && i_cpu_bus_req;
   wire xfer_end = (state == ST_T4) && (owner == OWN_DEPOSIT);
   wire [1:0] chan_syn = ctrl[chan][`DMARS_CTRL_SYN_HI:`DMARS_CTRL_SYN_LO];
   wire tsel_any = ctrl[0][`DMARS_CTRL_TSEL] || ctrl[1][`DMARS_CTRL_TSEL];
   wire timer_clr = (win_dma && ctrl[pick][`DMARS_CTRL_TSEL])
                    || !tsel_any;
   wire sel_ctrl0 = i_addr == `DMARS_OFF_CTRL0;
   wire sel_cnt0  = i_addr == `DMARS_OFF_COUNT0;
   wire sel_ctrl1 = i_addr == `DMARS_OFF_CTRL1;
   wire sel_cnt1  = i_addr == `DMARS_OFF_COUNT1;
   wire sel_halt  = i_addr == `DMARS_OFF_HALT;
   wire sel_stat  = i_addr == `DMARS_OFF_STATUS;
   wire [15:0] stat_word = {6'h00, gap_cnt, timer_req, halt_eff,
                            chan, owner, state[2:1]};
   wire [15:0] rd_mux =
      sel_ctrl0 ? {10'h000, ctrl[0]} :
      sel_cnt0  ? cnt[0] :
      sel_ctrl1 ? {10'h000, ctrl[1]} :
      sel_cnt1  ? cnt[1] :
      sel_halt  ? {14'h0000, slave_mode, halt_flag} :
      sel_stat  ? stat_word : 16'h0000;

   //////////////////////////////////////////////////////////////////////
   // Next bus cycle: fetch is always followed by its deposit.
   always_comb
   begin
      next_state = state;
      next_owner = owner;
      case (state)
         ST_IDLE, ST_T4:
         begin
            if (in_t4_fetch)
            begin
               next_state = ST_T1;
               next_owner = OWN_DEPOSIT;
            end
            else if (win_hold)
            begin
               next_state = ST_HOLD;
               next_owner = OWN_NONE;
            end
            else if (win_ref)
            begin
               next_state = ST_T1;
               next_owner = OWN_REFRESH;
            end
            else if (win_dma)
            begin
               next_state = ST_T1;
               next_owner = OWN_FETCH;
            end
            else if (win_cpu)
            begin
               next_state = ST_T1;
               next_owner = OWN_CPU;
            end
            else
            begin
               next_state = ST_IDLE;
               next_owner = OWN_NONE;
            end
         end
         ST_T1:   next_state = ST_T2;
         ST_T2:   next_state = ST_T3;
         ST_T3:   next_state = i_bus_ready ? ST_T4 : ST_T3;
         ST_HOLD: next_state = i_hold_req ? ST_HOLD : ST_IDLE;
         default:
         begin
            next_state = ST_IDLE;
            next_owner = OWN_NONE;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////
   // Sequencer, channel choice and bus release counter.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state   <= ST_IDLE;
         owner   <= OWN_NONE;
         chan    <= 1'b0;
         last_ch <= 1'b0;
         gap_cnt <= 2'h0;
      end
      else
      begin
         state <= next_state;
         owner <= next_owner;
         if (win_dma)
         begin
            chan    <= pick;
            last_ch <= pick;
         end
         if (xfer_end && (chan_syn == SYN_DST))
            gap_cnt <= 2'(`DMARS_DST_GAP_CLK);
         else if (gap_cnt != 2'h0)
            gap_cnt <= gap_cnt - 2'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Registers, counts, timer latch and halt flag.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ctrl[0]    <= `DMARS_CTRL_RST;
         ctrl[1]    <= `DMARS_CTRL_RST;
         cnt[0]     <= `DMARS_COUNT_RST;
         cnt[1]     <= `DMARS_COUNT_RST;
         halt_flag  <= 1'b0;
         slave_mode <= 1'b0;
         timer_req  <= 1'b0;
         o_rdata    <= 16'h0000;
      end
      else
      begin
         o_rdata <= i_rd ? rd_mux : 16'h0000;
         for (int c = 0; c < 2; c++)
         begin
            if (in_t4_fetch && (chan == c))  // Before the deposit's slot.
            begin
               cnt[c] <= cnt[c] - 16'h0001;
               if ((cnt[c] == 16'h0001) &&
                   (ctrl[c][`DMARS_CTRL_TCSTOP] ||
                    ctrl[c][2:1] == SYN_NONE))
                  ctrl[c][`DMARS_CTRL_START] <= 1'b0;
            end
         end
         if (i_wr && sel_ctrl0)
            ctrl[0] <= i_wdata[5:0];
         if (i_wr && sel_ctrl1)
            ctrl[1] <= i_wdata[5:0];
         if (i_wr && sel_cnt0)
            cnt[0] <= i_wdata;
         if (i_wr && sel_cnt1)
            cnt[1] <= i_wdata;
         // A timeout beats a transfer's clear in the same cycle; with no timer channel it is ignored.
         if (i_timer_max && tsel_any)
            timer_req <= 1'b1;
         else if (timer_clr)
            timer_req <= 1'b0;
         if (i_wr && sel_halt)
            slave_mode <= i_wdata[`DMARS_HALT_SLAVE];
         // NMI beats a software or return clear.
         if (i_nmi)
            halt_flag <= 1'b1;
         else if (i_wr && sel_halt)
            halt_flag <= i_wdata[`DMARS_HALT_FLAG];
         else if (i_intr_return)
            halt_flag <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Pin outputs decoded from the sequencer flops.
   wire active = (state != ST_IDLE) && (state != ST_HOLD);
   assign o_fetch_cycle      = active && (owner == OWN_FETCH);
   assign o_deposit_cycle    = active && (owner == OWN_DEPOSIT);
   assign o_dma_cycle_status = o_fetch_cycle || o_deposit_cycle;
   assign o_first_bus_state  = state == ST_T1;
   assign o_second_bus_state = state == ST_T2;
   assign o_dma_channel      = chan;
   assign o_cpu_cycle        = active && (owner == OWN_CPU);
   assign o_refresh_cycle    = active && (owner == OWN_REFRESH);
   assign o_hold_ack         = state == ST_HOLD;

   //////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [2:0] age;  // Clocks since reset, saturating.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end

   a_pair_kept: assert property (in_t4_fetch |=>
      (state == ST_T1) && (owner == OWN_DEPOSIT))
      else $error("deposit did not follow fetch");
   a_hold_first: assert property (win_dma |->
      !i_hold_req && !i_refresh_req)
      else $error("dma won over hold or refresh");
   a_req_delay: assert property ((age > 3'h5) |->
      rq.drq_seen == $past(i_drq, 4))
      else $error("request latency not four clocks");
   a_dst_release: assert property (xfer_end && chan_syn == SYN_DST
      |=> !o_fetch_cycle [*2])
      else $error("destination release too short");
   a_unsync_stop: assert property (in_t4_fetch && cnt[chan] == 16'h0001
      && chan_syn == SYN_NONE && !i_wr |=> !ctrl[$past(chan)][0])
      else $error("unsynchronized channel did not stop");
   a_timer_once: assert property (win_dma && ctrl[pick][3]
      && !i_timer_max |=> !timer_req)
      else $error("timer request survived its transfer");
   a_halt_block: assert property (halt_eff |-> !win_dma)
      else $error("dma started while halted");
   a_nmi_sets: assert property (i_nmi |=> halt_flag)
      else $error("nmi did not set halt");
   a_prio_rank: assert property (req == 2'h3 && pri0 != pri1
      |-> pick == pri1)
      else $error("priority rank ignored");
   a_tie_alt: assert property (win_dma && req == 2'h3 && pri0 == pri1
      |=> chan != $past(last_ch))
      else $error("equal priority did not alternate");
   a_one_win: assert property ($onehot0({win_hold, win_ref,
      win_dma, win_cpu}))
      else $error("more than one winner");
   c_dst_xfer: cover property (xfer_end && chan_syn == SYN_DST);
   c_nmi_halt: cover property (i_nmi ##1 halt_eff && req == 2'h0);
   c_tie_alt:  cover property (win_dma && req == 2'h3 && pri0 == pri1);
   c_hold:     cover property (win_hold && (req != 2'h0));

endmodule // dmars_seq

// ---- hw/dmars_defines.svh ----
`ifndef DMARS_DEFINES_SVH
`define DMARS_DEFINES_SVH

// Register bus widths.
`define DMARS_ADDR_W        8
`define DMARS_DATA_W        16

// Register byte addresses, one aligned word each.
`define DMARS_OFF_CTRL0     8'h00
`define DMARS_OFF_COUNT0    8'h04
`define DMARS_OFF_CTRL1     8'h08
`define DMARS_OFF_COUNT1    8'h0C
`define DMARS_OFF_HALT      8'h10
`define DMARS_OFF_STATUS    8'h14

// Channel control field positions.
`define DMARS_CTRL_W        6
`define DMARS_CTRL_START    0
`define DMARS_CTRL_SYN_LO   1
`define DMARS_CTRL_SYN_HI   2
`define DMARS_CTRL_TSEL     3
`define DMARS_CTRL_PRI      4
`define DMARS_CTRL_TCSTOP   5

// Halt register field positions.
`define DMARS_HALT_FLAG     0
`define DMARS_HALT_SLAVE    1

// Reset values.
`define DMARS_CTRL_RST      6'h00
`define DMARS_COUNT_RST     16'h0000

// Timing counts in clocks.
`define DMARS_REQ_LAT_CLK   4
`define DMARS_DST_GAP_CLK   2

`endif

// ---- hw/dmars_pkg.sv ----
package dmars_pkg;

   // Bus sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1   = 3'b001,
      ST_T2   = 3'b010,
      ST_T3   = 3'b011,
      ST_T4   = 3'b100,
      ST_HOLD = 3'b101
   } dmars_state_t;

   // Owner of the current bus cycle.
   typedef enum logic [2:0] {
      OWN_NONE    = 3'b000,
      OWN_CPU     = 3'b001,
      OWN_REFRESH = 3'b010,
      OWN_FETCH   = 3'b011,
      OWN_DEPOSIT = 3'b100
   } dmars_owner_t;

   // Synchronization select encoding.
   typedef enum logic [1:0] {
      SYN_NONE = 2'b00,
      SYN_SRC  = 2'b01,
      SYN_DST  = 2'b10,
      SYN_OFF  = 2'b11
   } dmars_sync_t;

endpackage

// ---- hw/dmars_req_if.sv ----
`timescale 1ns/1ps
// Carries the raw request pins to the synchroniser and the delayed,
// clock-aligned requests back to the arbiter.
interface dmars_req_if;
   logic [1:0] drq_pin;   // Raw request pins.
   logic [1:0] drq_seen;  // Requests as the arbiter sees them.
   modport sync_side (input drq_pin, output drq_seen);
   modport arb_side  (output drq_pin, input drq_seen);
endinterface

// ---- hw/dmars_req_sync.sv ----
`timescale 1ns/1ps
`include "dmars_defines.svh"
// Two-flop synchroniser followed by a delay line so that a request seen
// at a bus opportunity was on the pin a fixed number of clocks earlier.
module dmars_req_sync
   import dmars_pkg::*;
#(
   parameter int LAT = `DMARS_REQ_LAT_CLK
)(
   input  wire logic    i_clk,  // Processor clock.
   input  wire logic    i_rst,  // Synchronous reset, active high.
   dmars_req_if.sync_side rq    // Pins in, delayed requests out.
);

   logic [1:0] stage [LAT];     // Stage 0 is read only by stage 1.

   //////////////////////////////////////////////////////////////////////
   // Shift the pins through the chain every clock.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < LAT; i++)
            stage[i] <= 2'h0;
      end
      else
      begin
         stage[0] <= rq.drq_pin;
         for (int i = 1; i < LAT; i++)
            stage[i] <= stage[i-1];
      end
   end

   assign rq.drq_seen = stage[LAT-1];

endmodule // dmars_req_sync

// ---- verif/dmars_periph.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Peripheral that asks for a set number of transfers on one request pin.
module dmars_periph #(
   parameter logic CH  = 1'b0, // Channel that this device serves.
   parameter logic DST = 1'b0  // High when it is the data destination.
)(
   input  wire logic       i_clk,     // Processor clock.
   input  wire logic       i_rst,     // Sync reset, active high.
   input  wire logic       i_load,    // Load a new transfer demand.
   input  wire logic [7:0] i_want,    // Transfers wanted.
   input  wire logic       i_t2,      // Second bus state.
   input  wire logic       i_fetch,   // Fetch cycle running.
   input  wire logic       i_deposit, // Deposit cycle running.
   input  wire logic       i_chan,    // Channel of the running cycle.
   output logic            o_drq      // Request pin.
);
   logic [7:0] left; // Transfers still wanted.
   // Acknowledge is decoded from the cycle that touches this device.
   wire ack = i_t2 && (i_chan == CH) && (DST ? i_deposit : i_fetch);
   // The demand drops one count per acknowledge, so the pin falls on the
   // edge after the last acknowledge, in time for a source device but one clock too late for a destination.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         left <= 8'h00;
      else if (i_load)
         left <= i_want;
      else if (ack && left != 8'h00)
         left <= left - 8'h01;
   end
   // The pin stays up until the device has all it wants.
   assign o_drq = (left != 8'h00);
endmodule // dmars_periph

// ---- verif/dmars_seq_tb.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Self-checking bench: reads and transfers are noted in queues.
module dmars_seq_tb;
   logic        i_clk = 1'b0;  // Processor clock.
   logic        i_rst = 1'b1;  // Sync reset.
   logic        hold, refr, cpu, rdy;
   logic        tmax, nmi, interrupt_return, wr, rd;
   logic [7:0]  addr, want;
   logic [15:0] wdata;
   logic [1:0]  ld;
   wire  [1:0]  dma_request_input;
   logic        rnd = 1'b0, rd_d = 1'b0, pd = 1'b0;
   wire  [15:0] rdata;
   wire         dstat, t1, t2, fet, dep, ch, cpuc, refc, hack;
   int          miscompares = 0, checks = 0, cyc = 0, tf = 0, tfp = 0;
   int          trise = 0;
   logic [15:0] rdq[$]; // Read data still expected.
   logic        chq[$]; // Channels of fetches still expected.

   always #12.5 i_clk = ~i_clk;

   dmars_seq dmars_seq_i (.i_clk(i_clk), .i_rst(i_rst), .i_drq(dma_request_input),
      .i_hold_req(hold), .i_refresh_req(refr), .i_cpu_bus_req(cpu),
      .i_bus_ready(rdy), .i_timer_max(tmax), .i_nmi(nmi),
      .i_intr_return(interrupt_return), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .o_dma_cycle_status(dstat),
      .o_first_bus_state(t1), .o_second_bus_state(t2), .o_fetch_cycle(fet),
      .o_deposit_cycle(dep), .o_dma_channel(ch), .o_cpu_cycle(cpuc),
      .o_refresh_cycle(refc), .o_hold_ack(hack));
   dmars_periph #(.CH(1'b0), .DST(1'b0)) dmars_periph_i (.i_clk(i_clk),
      .i_rst(i_rst), .i_load(ld[0]), .i_want(want), .i_t2(t2),
      .i_fetch(fet), .i_deposit(dep), .i_chan(ch), .o_drq(dma_request_input[0]));
   dmars_periph #(.CH(1'b1), .DST(1'b1)) dmars_periph_d (.i_clk(i_clk),
      .i_rst(i_rst), .i_load(ld[1]), .i_want(want), .i_t2(t2),
      .i_fetch(fet), .i_deposit(dep), .i_chan(ch), .o_drq(dma_request_input[1]));

   // Compares one value and counts the result.
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // Prints the verdict and stops.
   task automatic complete_run;
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One register write cycle.
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask

   // One register read cycle; the expected word goes to the queue.
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      rdq.push_back(e);
      @(posedge i_clk);
      rd <= 0;
   endtask

   // Waits, bounded, until every expected fetch has been seen.
   task automatic settle;
      int n;
      n = 0;
      while (chq.size() != 0 && n < 400)
      begin
         @(posedge i_clk);
         n++;
      end
      repeat (16) @(posedge i_clk);
      check("pending fetches", 16'(chq.size()), 16'h0000);
   endtask

   // Arms both channels under halt, then frees them at the same moment.
   task automatic arm2(input logic [15:0] c0, input logic [15:0] c1,
                       input logic [3:0] ord);
      wr_reg(8'h10, 16'h0001);
      wr_reg(8'h04, 16'h0002);
      wr_reg(8'h0C, 16'h0002);
      wr_reg(8'h00, c0);
      wr_reg(8'h08, c1);
      repeat (20) @(posedge i_clk);
      for (int k = 3; k >= 0; k--)
         chq.push_back(ord[k]);
      wr_reg(8'h10, 16'h0000);
      settle();
   endtask

   // Cycle count, read tracking and random wait states.
   always @(posedge i_clk)
   begin
      cyc++;
      rd_d <= rd;
      rdy <= rnd ? ($urandom % 4 != 0) : 1'b1;
   end

   // Watches outputs away from the clock edge and takes the oldest notes.
   always @(negedge i_clk)
   begin
      if (rd_d)
         check("read data", rdata, rdq.pop_front());
      if (dma_request_input[0] && !pd)
         trise = cyc;
      pd = dma_request_input[0];
      if (fet && t1)
      begin
         tfp = tf;
         tf = cyc;
         check("dma status", {15'h0000, dstat}, 16'h0001);
         if (chq.size() == 0)
            check("unexpected fetch", 16'h0001, 16'h0000);
         else
            check("fetch channel", {15'h0000, ch}, {15'h0000, chq.pop_front()});
      end
   end

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      complete_run();
   end

   // Main sequence.
   initial
   begin
      void'($urandom(32'h2d5f));
      {hold, refr, cpu, tmax, nmi, interrupt_return, wr, rd} <= 8'h00;
      {addr, want, ld} <= 18'h00000;
      wdata <= 16'h0000;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      rd_reg(8'h00, 16'h0000);
      rd_reg(8'h04, 16'h0000);
      rd_reg(8'h10, 16'h0000);
      wr_reg(8'h18, 16'hFFFF);
      rd_reg(8'h18, 16'h0000);
      // Unsynchronized run of three, without the stop option.
      wr_reg(8'h04, 16'h0003);
      rd_reg(8'h04, 16'h0003);
      repeat (3) chq.push_back(1'b0);
      wr_reg(8'h00, 16'h0001);
      settle();
      rd_reg(8'h00, 16'h0000);
      rd_reg(8'h04, 16'h0000);
      // Priority: equal, channel 0 high, channel 1 high.
      rnd <= 1'b1;
      arm2(16'h0001, 16'h0001, 4'b1010);
      arm2(16'h0011, 16'h0001, 4'b0011);
      arm2(16'h0001, 16'h0011, 4'b1100);
      rnd <= 1'b0;
      // Slave configuration ignores the halt flag.
      wr_reg(8'h10, 16'h0003);
      rd_reg(8'h10, 16'h0003);
      wr_reg(8'h04, 16'h0001);
      chq.push_back(1'b0);
      wr_reg(8'h00, 16'h0001);
      settle();
      wr_reg(8'h10, 16'h0000);
      // NMI in mid-run: the transfer in progress completes, then halt.
      wr_reg(8'h04, 16'h0003);
      chq.push_back(1'b0);
      wr_reg(8'h00, 16'h0001);
      repeat (2) @(posedge i_clk);
      nmi <= 1'b1;
      @(posedge i_clk);
      nmi <= 1'b0;
      repeat (30) @(posedge i_clk);
      rd_reg(8'h10, 16'h0001);
      rd_reg(8'h04, 16'h0002);
      repeat (2) chq.push_back(1'b0);
      interrupt_return <= 1'b1;
      @(posedge i_clk);
      interrupt_return <= 1'b0;
      settle();
      rd_reg(8'h10, 16'h0000);
      // Hold, then refresh, keep an armed channel off the bus.
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(8'h04, 16'h0001);
         hold <= (k == 0);
         refr <= (k == 1);
         wr_reg(8'h00, 16'h0001);
         repeat (20) @(posedge i_clk);
         check("hold ack", {15'h0000, hack}, {15'h0000, k == 0});
         check("refresh cycle", {15'h0000, refc}, {15'h0000, k == 1});
         chq.push_back(1'b0);
         hold <= 1'b0;
         refr <= 1'b0;
         settle();
      end
      // Two timeouts before service give one transfer.
      wr_reg(8'h10, 16'h0001);
      wr_reg(8'h04, 16'h0004);
      wr_reg(8'h0C, 16'h0004);
      wr_reg(8'h00, 16'h001F);
      wr_reg(8'h08, 16'h000F);
      repeat (2)
      begin
         tmax <= 1'b1;
         @(posedge i_clk);
         tmax <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
      chq.push_back(1'b0);
      wr_reg(8'h10, 16'h0000);
      settle();
      wr_reg(8'h00, 16'h0000);
      wr_reg(8'h08, 16'h0000);
      // Source synchronized: latency, single transfer, back to back.
      wr_reg(8'h04, 16'h0010);
      wr_reg(8'h00, 16'h0003);
      chq.push_back(1'b0);
      want <= 8'h01;
      ld <= 2'b01;
      @(posedge i_clk);
      ld <= 2'b00;
      settle();
      check("request latency", 16'(tf - trise), 16'h0005);
      repeat (3) chq.push_back(1'b0);
      want <= 8'h03;
      ld <= 2'b01;
      @(posedge i_clk);
      ld <= 2'b00;
      settle();
      check("source spacing", 16'(tf - tfp), 16'h0008);
      // Destination synchronized with terminal count stop.
      wr_reg(8'h0C, 16'h0002);
      wr_reg(8'h08, 16'h0025);
      repeat (2) chq.push_back(1'b1);
      want <= 8'h08;
      ld <= 2'b10;
      @(posedge i_clk);
      ld <= 2'b00;
      settle();
      check("dest spacing", 16'(tf - tfp), 16'h000A);
      // Again with the CPU wanting the bus: it takes the release gap.
      cpu <= 1'b1;
      wr_reg(8'h0C, 16'h0002);
      wr_reg(8'h08, 16'h0025);
      repeat (2) chq.push_back(1'b1);
      settle();
      check("cpu gap spacing", 16'(tf - tfp), 16'h000C);
      check("cpu cycle", {15'h0000, cpuc}, 16'h0001);
      cpu <= 1'b0;
      complete_run();
   end
endmodule // dmars_seq_tb
